/* File: core/gdc_pkg.sv */
// Constants shared by the gate driver control bank and its serial link.
`default_nettype none
package gdc_pkg;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'd16;
  localparam logic [4:0] FRAME_CNT_MAX = 5'd17;
  localparam int OP_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_BRIDGE_GENERAL = 7'h01;
  localparam logic [6:0] ADDR_WATCHDOG_PERIOD = 7'h02;
  localparam logic [6:0] ADDR_PROTECTION_DIAG = 7'h03;
  localparam logic [6:0] ADDR_PRECHARGE = 7'h04;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BRIDGE_GENERAL = 8'h21;
  localparam logic [7:0] RST_WATCHDOG_PERIOD = 8'h84;
  localparam logic [7:0] RST_PROTECTION_DIAG = 8'h01;
  localparam logic [7:0] RST_PRECHARGE = 8'h0f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GEN_CLK_SEL = 7;
  localparam int GEN_DRV_ON = 6;
  localparam int GEN_OV_SCOPE = 5;
  localparam int GEN_GLITCH = 4;
  localparam int GEN_RANGE_EXT = 3;
  localparam int GEN_UNLOCK = 2;
  localparam int GEN_FMOD_MSB = 1;
  localparam int WDG_CHECKSUM = 7;
  localparam int WDG_PER_MSB = 2;
  localparam logic [7:0] WDG_READ_MASK = 8'h87;
  localparam int PDG_WD_OFF = 7;
  localparam int PDG_TW_MASK = 6;
  localparam int PDG_PD3 = 5;
  localparam int PDG_PD2 = 4;
  localparam int PDG_PD1 = 3;
  localparam int PDG_VDS_MSB = 2;
  localparam int PRE_TIME_MSB = 7;
  localparam int PRE_TIME_LSB = 6;
  localparam int PRE_CUR_MSB = 5;

  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int STS_GEF = 7;
  localparam int STS_DS_ERR = 2;
  localparam int STS_TW = 1;
  localparam int STS_SPI_ERR = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int WD_TICK_NS = 1000000;
  localparam int WD_TICK_CYCLES = WD_TICK_NS / SYS_CLK_PERIOD_NS;
  localparam int GLITCH_NS = 40;
  localparam int GLITCH_CYCLES = (GLITCH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [9:0] WD_PERIOD_MS [8] = '{10'd2, 10'd4, 10'd8, 10'd16, 10'd64, 10'd128, 10'd256, 10'd512};
endpackage
`default_nettype wire

/* File: core/gdc_sync.sv */
// Three-stage input synchroniser whose output follows once stages two and three agree.
`default_nettype none
module gdc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic async_i,
  output logic sync_o
);
  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  logic out_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ff1_q <= RESET_VAL;
      ff2_q <= RESET_VAL;
      ff3_q <= RESET_VAL;
    end else begin
      ff1_q <= async_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= RESET_VAL;
    end else if (ff2_q == ff3_q) begin
      out_q <= ff3_q;
    end
  end

  assign sync_o = out_q;
endmodule
`default_nettype wire

/* File: core/gdc_spi_link.sv */
// Serial link logic clocked by the serial clock: receive shift, bit count and response shift.
`default_nettype none
module gdc_spi_link
  import gdc_pkg::*;
(
  // Link clock and resets
  input wire logic spi_sclk,
  input wire logic arst_n,
  input wire logic spi_csn_n,
  // Serial data
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  // Towards the register bank
  input wire logic [15:0] resp_word_i,
  output logic [15:0] rx_word_o,
  output logic [4:0] rx_count_o,
  output logic frame_tgl_o
);
  logic frame_clr_n;
  logic started_q;
  logic [15:0] rx_word_q;
  logic [4:0] rx_count_q;
  logic frame_tgl_q;
  logic [3:0] tx_idx_q;

  // Chip select high clears the per-frame state without any clock edge.
  assign frame_clr_n = arst_n & ~spi_csn_n;

  always_ff @(posedge spi_sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // Word and count survive the frame end so the bank can collect them.
  always_ff @(posedge spi_sclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_word_q <= 16'h0000;
      rx_count_q <= 5'h00;
      frame_tgl_q <= 1'b0;
    end else begin
      rx_word_q <= {rx_word_q[14:0], spi_sdi};
      if (!started_q) begin
        rx_count_q <= 5'h01;
        frame_tgl_q <= ~frame_tgl_q;
      end else if (rx_count_q != FRAME_CNT_MAX) begin
        rx_count_q <= rx_count_q + 5'h01;
      end
    end
  end

  always_ff @(negedge spi_sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      tx_idx_q <= 4'hf;
    end else if (started_q) begin
      tx_idx_q <= tx_idx_q - 4'h1;
    end
  end

  assign spi_sdo_oe = ~spi_csn_n;
  assign spi_sdo_o = resp_word_i[tx_idx_q];
  assign rx_word_o = rx_word_q;
  assign rx_count_o = rx_count_q;
  assign frame_tgl_o = frame_tgl_q;
endmodule
`default_nettype wire

/* File: core/gdc_bank.sv */
// Control register bank of the three half-bridge gate driver behind its serial port.
//
// Summary of operation
// - All control registers reset to their defaults.
// - Reserved bits read zero; host writes zero.
// - Operation bit zero reads, leaves registers unchanged.
// - Only host writes ever change stored values.
// - Bit 7 selects bridge clock 37.5/18.75 MHz.
// - Bit 6 enables or disables whole bridge driver.
// - Overvoltage shuts one bridge or all drivers.
// - Bit 4 enables comparator glitch filter.
// - Bit 3 selects extended gate current column.
// - Bits 1:0 select frequency modulation rate.
// - Watchdog off needs unlock in previous frame.
// - Watchdog off bit disables only after unlock.
// - Clearing watchdog off re-enables watchdog at once.
// - Bad watchdog parity sets serial error flag.
// - Bits 2:0 select watchdog period 2-512 ms.
// - Thermal warning mask gates global error only.
// - Bits 5:3 enable bridge off-state pull-downs.
// - Bits 2:0 select drain-source threshold.
// - Bits 5:0 select precharge current.
// - Bits 7:6 select precharge time.
`default_nettype none
module gdc_bank
  import gdc_pkg::*;
#(
  parameter int WD_TICK = WD_TICK_CYCLES
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  // Serial pins
  input wire logic spi_csn_n,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  // Monitor inputs
  input wire logic [2:0] ds_overvolt_raw,
  input wire logic thermal_warning_raw,
  // Status handling
  input wire logic serial_error_clear,
  output logic serial_error_flag,
  output logic global_error_flag,
  // General configuration
  output logic bridge_clock_select,
  output logic bridge_driver_on,
  output logic overvoltage_shutoff_scope,
  output logic comparator_glitch_filter,
  output logic current_range_extend,
  output logic [1:0] freq_modulation_select,
  // Watchdog
  output logic [2:0] watchdog_period_select,
  output logic watchdog_off,
  output logic watchdog_timeout,
  // Protection and diagnosis
  output logic thermal_warning_mask,
  output logic bridge1_offstate_pulldown,
  output logic bridge2_offstate_pulldown,
  output logic bridge3_offstate_pulldown,
  output logic [2:0] drain_source_threshold,
  output logic [2:0] gate_shutoff,
  // Precharge
  output logic [5:0] precharge_current_select,
  output logic [1:0] precharge_time_select
);
  // ---------------------------------------------------------------
  // Serial link and crossings
  // ---------------------------------------------------------------
  logic [15:0] resp_q;
  logic [15:0] rx_word;
  logic [4:0] rx_count;
  logic frame_tgl;
  logic csn_s;
  logic tgl_s;

  gdc_spi_link u_link (
    .spi_sclk(spi_sclk),
    .arst_n(arst_n),
    .spi_csn_n(spi_csn_n),
    .spi_sdi(spi_sdi),
    .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe(spi_sdo_oe),
    .resp_word_i(resp_q),
    .rx_word_o(rx_word),
    .rx_count_o(rx_count),
    .frame_tgl_o(frame_tgl)
  );

  gdc_sync #(.RESET_VAL(1'b1)) u_csn_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .async_i(spi_csn_n),
    .sync_o(csn_s)
  );

  gdc_sync #(.RESET_VAL(1'b0)) u_tgl_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .async_i(frame_tgl),
    .sync_o(tgl_s)
  );

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  logic csn_prev_q;
  logic tgl_seen_q;
  logic frame_end;
  logic new_frame;
  logic len_ok;
  logic op_write;
  logic [6:0] addr;
  logic [7:0] data;
  logic addr_mapped;
  logic parity_ok;
  logic is_wdog;
  logic frame_err;
  logic wr_en;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csn_prev_q <= 1'b1;
      tgl_seen_q <= 1'b0;
    end else begin
      csn_prev_q <= csn_s;
      if (frame_end) begin
        tgl_seen_q <= tgl_s;
      end
    end
  end

  // The link word is stable here: no serial clock runs while chip select is high.
  assign frame_end = csn_s & ~csn_prev_q;
  assign new_frame = frame_end & (tgl_s != tgl_seen_q);
  assign len_ok = (rx_count == FRAME_LEN);
  assign op_write = rx_word[OP_POS];
  assign addr = rx_word[ADDR_MSB:ADDR_LSB];
  assign data = rx_word[DATA_MSB:0];
  assign addr_mapped = (addr >= ADDR_BRIDGE_GENERAL) && (addr <= ADDR_PRECHARGE);
  assign is_wdog = (addr == ADDR_WATCHDOG_PERIOD);
  assign parity_ok = ~^data;
  // A read frame never reaches the write enable.
  assign frame_err = new_frame & (~len_ok | ~addr_mapped | (op_write & is_wdog & ~parity_ok));
  assign wr_en = new_frame & len_ok & addr_mapped & op_write & ~(is_wdog & ~parity_ok);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [7:0] gen_q;
  logic [7:0] wdg_q;
  logic [7:0] pdg_q;
  logic [7:0] pre_q;
  logic unlock_armed_q;
  logic wd_off_d;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_q <= RST_BRIDGE_GENERAL;
    end else if (wr_en && addr == ADDR_BRIDGE_GENERAL) begin
      gen_q <= data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdg_q <= RST_WATCHDOG_PERIOD;
    end else if (wr_en && is_wdog) begin
      wdg_q <= data & WDG_READ_MASK;
    end
  end

  // Only the frame right after an unlock write may set the watchdog off bit.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_armed_q <= 1'b0;
    end else if (new_frame) begin
      unlock_armed_q <= wr_en && (addr == ADDR_BRIDGE_GENERAL) && data[GEN_UNLOCK];
    end
  end

  always_comb begin
    wd_off_d = 1'b0;
    if (data[PDG_WD_OFF]) begin
      wd_off_d = unlock_armed_q | pdg_q[PDG_WD_OFF];
    end else begin
      wd_off_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pdg_q <= RST_PROTECTION_DIAG;
    end else if (wr_en && addr == ADDR_PROTECTION_DIAG) begin
      pdg_q <= {wd_off_d, data[PDG_TW_MASK:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= RST_PRECHARGE;
    end else if (wr_en && addr == ADDR_PRECHARGE) begin
      pre_q <= data;
    end
  end

  assign bridge_clock_select = gen_q[GEN_CLK_SEL];
  assign bridge_driver_on = gen_q[GEN_DRV_ON];
  assign overvoltage_shutoff_scope = gen_q[GEN_OV_SCOPE];
  assign comparator_glitch_filter = gen_q[GEN_GLITCH];
  assign current_range_extend = gen_q[GEN_RANGE_EXT];
  assign freq_modulation_select = gen_q[GEN_FMOD_MSB:0];
  assign watchdog_period_select = wdg_q[WDG_PER_MSB:0];
  assign watchdog_off = pdg_q[PDG_WD_OFF];
  assign thermal_warning_mask = pdg_q[PDG_TW_MASK];
  assign bridge3_offstate_pulldown = pdg_q[PDG_PD3];
  assign bridge2_offstate_pulldown = pdg_q[PDG_PD2];
  assign bridge1_offstate_pulldown = pdg_q[PDG_PD1];
  assign drain_source_threshold = pdg_q[PDG_VDS_MSB:0];
  assign precharge_current_select = pre_q[PRE_CUR_MSB:0];
  assign precharge_time_select = pre_q[PRE_TIME_MSB:PRE_TIME_LSB];

  // ---------------------------------------------------------------
  // Monitor inputs and protection
  // ---------------------------------------------------------------
  logic [2:0] ds_s;
  logic [2:0] ds_f;
  logic tw_s;
  logic ds_any;

  gdc_sync #(.RESET_VAL(1'b0)) u_tw_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .async_i(thermal_warning_raw),
    .sync_o(tw_s)
  );

  for (genvar i = 0; i < 3; i++) begin : g_ds
    logic [2:0] run_q;

    gdc_sync #(.RESET_VAL(1'b0)) u_ds_sync (
      .clk(sys_clk),
      .arst_n(arst_n),
      .async_i(ds_overvolt_raw[i]),
      .sync_o(ds_s[i])
    );

    // A comparator pulse must last the filter time before it counts.
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        run_q <= 3'h0;
      end else if (!ds_s[i]) begin
        run_q <= 3'h0;
      end else if (run_q != 3'(GLITCH_CYCLES)) begin
        run_q <= run_q + 3'h1;
      end
    end

    assign ds_f[i] = comparator_glitch_filter ? (run_q == 3'(GLITCH_CYCLES)) : ds_s[i];
  end

  assign ds_any = |ds_f;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_shutoff <= 3'h7;
    end else if (!bridge_driver_on) begin
      gate_shutoff <= 3'h7;
    end else if (overvoltage_shutoff_scope) begin
      gate_shutoff <= ds_f;
    end else begin
      gate_shutoff <= {3{ds_any}};
    end
  end

  // ---------------------------------------------------------------
  // Error flags and response word
  // ---------------------------------------------------------------
  logic spi_err_q;
  logic spi_err_next;
  logic [7:0] status_next;
  logic [7:0] read_data;

  // A new error in the clearing cycle keeps the flag set.
  assign spi_err_next = frame_err | (spi_err_q & ~serial_error_clear);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_err_q <= 1'b0;
    end else begin
      spi_err_q <= spi_err_next;
    end
  end

  assign serial_error_flag = spi_err_q;
  assign global_error_flag = spi_err_q | ds_any | (tw_s & ~thermal_warning_mask);

  always_comb begin
    status_next = 8'h00;
    status_next[STS_SPI_ERR] = spi_err_next;
    status_next[STS_TW] = tw_s;
    status_next[STS_DS_ERR] = ds_any;
    status_next[STS_GEF] = spi_err_next | ds_any | (tw_s & ~thermal_warning_mask);
  end

  always_comb begin
    unique case (addr)
      ADDR_BRIDGE_GENERAL: read_data = gen_q;
      ADDR_WATCHDOG_PERIOD: read_data = wdg_q & WDG_READ_MASK;
      ADDR_PROTECTION_DIAG: read_data = pdg_q;
      ADDR_PRECHARGE: read_data = pre_q;
      default: read_data = 8'h00;
    endcase
  end

  // The next frame shifts out the status and the register addressed in this one.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_q <= 16'h0000;
    end else if (frame_end) begin
      resp_q <= {status_next, read_data};
    end
  end

  // ---------------------------------------------------------------
  // Watchdog timer
  // ---------------------------------------------------------------
  logic [$clog2(WD_TICK + 1)-1:0] tick_q;
  logic [9:0] ms_q;
  logic wd_kick;
  logic tick_end;
  logic [9:0] period_ms;

  assign wd_kick = wr_en & is_wdog;
  assign tick_end = (tick_q == ($clog2(WD_TICK + 1))'(WD_TICK - 1));
  assign period_ms = WD_PERIOD_MS[watchdog_period_select];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= '0;
      ms_q <= 10'h000;
      watchdog_timeout <= 1'b0;
    end else begin
      watchdog_timeout <= 1'b0;
      if (wd_kick || watchdog_off) begin
        tick_q <= '0;
        ms_q <= 10'h000;
      end else if (tick_end) begin
        tick_q <= '0;
        if (ms_q == period_ms - 10'h001) begin
          ms_q <= 10'h000;
          watchdog_timeout <= 1'b1;
        end else begin
          ms_q <= ms_q + 10'h001;
        end
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/gdc_host.sv */
// Serial master model that plays the host side of the control bank link.
`default_nettype none
module gdc_host (
  // Serial pins
  output var logic spi_sclk,
  output var logic spi_csn_n,
  output var logic spi_sdi,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spi_sclk = 1'b0;
    spi_csn_n = 1'b1;
    spi_sdi = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame transfer
  // ---------------------------------------------------------------
  // The clock runs only inside a frame; a released SDO shows the inverse of the last bit.
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_csn_n = 1'b0;
    #12;
    for (int i = 0; i < nbits; i++) begin
      spi_sdi = tx[15 - i];
      #6;
      rx = {rx[14:0], spi_sdo_oe ? spi_sdo_o : ~rx[0]};
      spi_sclk = 1'b1;
      #6;
      spi_sclk = 1'b0;
    end
    #12;
    spi_csn_n = 1'b1;
    spi_sdi = 1'b0;
    #3000;
  endtask
endmodule
`default_nettype wire

/* File: test/gdc_bank_chk.sv */
// Concurrent checks on the control bank ports.
`default_nettype none
module gdc_bank_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Inputs
  input wire logic spi_csn_n,
  input wire logic [2:0] ds_overvolt_raw,
  input wire logic thermal_warning_raw,
  // Outputs
  input wire logic serial_error_flag,
  input wire logic global_error_flag,
  input wire logic bridge_clock_select,
  input wire logic bridge_driver_on,
  input wire logic overvoltage_shutoff_scope,
  input wire logic comparator_glitch_filter,
  input wire logic [1:0] freq_modulation_select,
  input wire logic [2:0] watchdog_period_select,
  input wire logic watchdog_off,
  input wire logic watchdog_timeout,
  input wire logic thermal_warning_mask,
  input wire logic [2:0] drain_source_threshold,
  input wire logic [2:0] gate_shutoff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Cycles since chip select was last seen low.
  logic [7:0] gap_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= 8'h00;
    end else if (!spi_csn_n) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  a_reset_defaults: assert property ($rose(arst_n) |-> {bridge_clock_select, bridge_driver_on,
    overvoltage_shutoff_scope, freq_modulation_select, watchdog_period_select, watchdog_off, drain_source_threshold}
    == 12'h2c1) else $error("outputs not at defaults after reset");
  a_cfg_quiet: assert property (!$stable({bridge_clock_select, bridge_driver_on, freq_modulation_select,
    watchdog_period_select, watchdog_off, drain_source_threshold}) |-> gap_q < 8'd12)
    else $error("configuration changed with no frame");
  a_sef_after_frame: assert property ($rose(serial_error_flag) |-> gap_q < 8'd12)
    else $error("serial error set with no frame");
  a_sef_in_gef: assert property (serial_error_flag |-> global_error_flag)
    else $error("serial error missing from global flag");
  a_tw_to_gef: assert property ((thermal_warning_raw && !thermal_warning_mask) [*8] |-> global_error_flag)
    else $error("unmasked warning not in global flag");
  a_tw_masked: assert property ((thermal_warning_mask && !serial_error_flag && ds_overvolt_raw == 3'b000) [*8]
    |-> !global_error_flag) else $error("masked warning in global flag");
  a_driver_off_all: assert property (!bridge_driver_on [*2] |-> gate_shutoff == 3'b111)
    else $error("driver off but gates not off");
  a_scope_all_off: assert property ((bridge_driver_on && !overvoltage_shutoff_scope && !comparator_glitch_filter
    && ds_overvolt_raw != 3'b000) [*8] |=> gate_shutoff == 3'b111) else $error("overvoltage did not stop all");
  a_scope_one_off: assert property ((bridge_driver_on && overvoltage_shutoff_scope && !comparator_glitch_filter
    && ds_overvolt_raw[0]) [*8] |=> gate_shutoff[0]) else $error("overvoltage did not stop bridge one");
  a_wd_off_quiet: assert property (watchdog_off [*2] |-> !watchdog_timeout)
    else $error("timeout while watchdog off");
  a_timeout_single: assert property (watchdog_timeout |=> !watchdog_timeout)
    else $error("timeout pulse too long");
endmodule
bind gdc_bank gdc_bank_chk u_chk (.sys_clk, .arst_n, .spi_csn_n, .ds_overvolt_raw, .thermal_warning_raw,
  .serial_error_flag, .global_error_flag, .bridge_clock_select, .bridge_driver_on, .overvoltage_shutoff_scope,
  .comparator_glitch_filter, .freq_modulation_select, .watchdog_period_select, .watchdog_off, .watchdog_timeout,
  .thermal_warning_mask, .drain_source_threshold, .gate_shutoff);
`default_nettype wire

/* File: test/gdc_bank_tb.sv */
// Self-checking bench for the gate driver control bank.
`default_nettype none
module gdc_bank_tb
  import gdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WDT = 10;
  typedef struct packed {logic [6:0] a; logic [7:0] d;} gdc_row_s;
  // Reserved bits written zero and watchdog bytes of even parity.
  localparam gdc_row_s ROWS [11] = '{'{7'h01, 8'hc8}, '{7'h01, 8'h52}, '{7'h01, 8'h33}, '{7'h01, 8'h61},
    '{7'h02, 8'h87}, '{7'h02, 8'h03}, '{7'h03, 8'h7a}, '{7'h03, 8'h05}, '{7'h04, 8'hc0}, '{7'h04, 8'h3f},
    '{7'h04, 8'h6a}};
  logic sys_clk, arst_n, serial_error_clear, thermal_warning_raw, spi_sclk, spi_csn_n, spi_sdi, spi_sdo_o;
  logic spi_sdo_oe, serial_error_flag, global_error_flag, bridge_clock_select, bridge_driver_on;
  logic overvoltage_shutoff_scope, comparator_glitch_filter, current_range_extend, watchdog_off, watchdog_timeout;
  logic thermal_warning_mask, bridge1_offstate_pulldown, bridge2_offstate_pulldown, bridge3_offstate_pulldown;
  logic [1:0] freq_modulation_select, precharge_time_select;
  logic [2:0] ds_overvolt_raw, watchdog_period_select, drain_source_threshold, gate_shutoff;
  logic [5:0] precharge_current_select;
  logic [15:0] rx;
  logic [7:0] d;
  int fails = 0;
  int tests_run = 0;
  int n;

  gdc_bank #(.WD_TICK(WDT)) dut (.sys_clk, .arst_n, .spi_sclk, .spi_csn_n, .spi_sdi, .spi_sdo_o, .spi_sdo_oe,
    .ds_overvolt_raw, .thermal_warning_raw, .serial_error_clear, .serial_error_flag, .global_error_flag,
    .bridge_clock_select, .bridge_driver_on, .overvoltage_shutoff_scope, .comparator_glitch_filter,
    .current_range_extend, .freq_modulation_select, .watchdog_period_select, .watchdog_off, .watchdog_timeout,
    .thermal_warning_mask, .bridge1_offstate_pulldown, .bridge2_offstate_pulldown, .bridge3_offstate_pulldown,
    .drain_source_threshold, .gate_shutoff, .precharge_current_select, .precharge_time_select);
  gdc_host host (.spi_sclk, .spi_csn_n, .spi_sdi, .spi_sdo_o, .spi_sdo_oe);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] pv(input logic [6:0] a);
    case (a)
      7'h01: pv = {bridge_clock_select, bridge_driver_on, overvoltage_shutoff_scope, comparator_glitch_filter,
        current_range_extend, 1'b0, freq_modulation_select};
      7'h02: pv = {5'h00, watchdog_period_select};
      7'h03: pv = {watchdog_off, thermal_warning_mask, bridge3_offstate_pulldown, bridge2_offstate_pulldown,
        bridge1_offstate_pulldown, drain_source_threshold};
      default: pv = {precharge_time_select, precharge_current_select};
    endcase
  endfunction

  function automatic logic [7:0] pm(input logic [6:0] a);
    pm = (a == 7'h01) ? 8'hfb : (a == 7'h02) ? 8'h07 : 8'hff;
  endfunction

  function automatic logic [7:0] rv(input logic [6:0] a);
    case (a)
      7'h01: rv = RST_BRIDGE_GENERAL;
      7'h02: rv = RST_WATCHDOG_PERIOD & WDG_READ_MASK;
      7'h03: rv = RST_PROTECTION_DIAG;
      default: rv = RST_PRECHARGE;
    endcase
  endfunction

  task automatic end_of_test();
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.xfer({1'b1, a, v}, 16, rx);
  endtask

  // The answer of a read arrives in the frame after it.
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    host.xfer({1'b0, a, 8'h00}, 16, rx);
    host.xfer({1'b0, a, 8'h00}, 16, rx);
    v = rx[7:0];
  endtask

  task automatic drv(input logic [2:0] ds, input logic tw);
    cyc(1);
    ds_overvolt_raw = ds;
    thermal_warning_raw = tw;
    cyc(20);
  endtask

  task automatic clr();
    cyc(1);
    serial_error_clear = 1'b1;
    cyc(1);
    serial_error_clear = 1'b0;
    cyc(1);
  endtask

  task automatic wait_to(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (watchdog_timeout !== 1'b1 && k < 200);
    if (k >= 200) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic rst();
    cyc(1);
    arst_n = 1'b0;
    cyc(16);
    arst_n = 1'b1;
    cyc(5);
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    arst_n = 1'b0;
    serial_error_clear = 1'b0;
    thermal_warning_raw = 1'b0;
    ds_overvolt_raw = 3'b000;
    rst();
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, d);
      chk(d, ROWS[i].d);
      chk(pv(ROWS[i].a), ROWS[i].d & pm(ROWS[i].a));
    end
    $display("Table test done");
    rst();
    for (int a = 1; a <= 4; a++) begin
      rd(7'(a), d);
      chk(d, rv(7'(a)));
      chk(pv(7'(a)), rv(7'(a)) & pm(7'(a)));
    end
    chk(gate_shutoff, 3'b111);
    $display("Reset test done");
    wr(ADDR_BRIDGE_GENERAL, 8'h61);
    drv(3'b001, 1'b0);
    chk(gate_shutoff, 3'b001);
    drv(3'b000, 1'b0);
    wr(ADDR_BRIDGE_GENERAL, 8'h41);
    drv(3'b010, 1'b0);
    chk(gate_shutoff, 3'b111);
    drv(3'b000, 1'b1);
    chk(global_error_flag, 1'b1);
    wr(ADDR_PROTECTION_DIAG, 8'h41);
    rd(ADDR_PROTECTION_DIAG, d);
    chk({rx[9], global_error_flag}, 2'b10);
    drv(3'b000, 1'b0);
    $display("Protection test done");
    wr(ADDR_PROTECTION_DIAG, 8'h80);
    chk(watchdog_off, 1'b0);
    wr(ADDR_BRIDGE_GENERAL, 8'h45);
    wr(ADDR_PROTECTION_DIAG, 8'h80);
    chk(watchdog_off, 1'b1);
    n = 0;
    repeat (100) begin
      @(posedge sys_clk);
      #1;
      n += int'(watchdog_timeout);
    end
    chk(16'(n), 16'h0000);
    wr(ADDR_PROTECTION_DIAG, 8'h00);
    chk(watchdog_off, 1'b0);
    $display("Unlock test done");
    wr(7'h05, 8'hff);
    rd(ADDR_PRECHARGE, d);
    chk({rx[8], serial_error_flag}, 2'b11);
    clr();
    chk(serial_error_flag, 1'b0);
    host.xfer({1'b1, ADDR_PRECHARGE, 8'h55}, 8, rx);
    chk({serial_error_flag, precharge_current_select}, {1'b1, 6'h0f});
    clr();
    wr(ADDR_WATCHDOG_PERIOD, 8'h01);
    chk({serial_error_flag, watchdog_period_select}, {1'b1, 3'b100});
    clr();
    $display("Refusal test done");
    wr(ADDR_WATCHDOG_PERIOD, 8'h00);
    wait_to(n);
    wait_to(n);
    chk(16'(n >= int'(WD_PERIOD_MS[0]) * WDT - 1 && n <= int'(WD_PERIOD_MS[0]) * WDT + 1), 16'h0001);
    $display("Watchdog test done");
    end_of_test();
  end
endmodule
`default_nettype wire
